// *** inc/sws_params.svh ***
// Constants for the repeated-fill command engine.
// Assumes inclusion by the engine only.
`ifndef SWS_PARAMS_SVH
`define SWS_PARAMS_SVH
`define SWS_ACT_WRITE_SAME 16'h0002
`define SWS_FN_PAT_BG 16'h0001
`define SWS_FN_SEC_BG 16'h0002
`define SWS_FN_PAT_BLK 16'h0101
`define SWS_FN_SEC_BLK 16'h0102
`define SWS_FN_SECTOR_BIT 1
`define SWS_FN_BLOCK_BIT 8
`define SWS_TF_ERR_OK 8'h00
`define SWS_TF_ERR_ABRT 8'h04
`define SWS_TF_XFER_LO 8'h01
`define SWS_TF_XFER_HI 8'h00
`define SWS_TF_STAT_OK 8'h50
`define SWS_TF_STAT_ERR 8'h51
`define SWS_EXT_BUSY 16'hffff
`define SWS_EXT_DONE 16'h0000
`define SWS_EXT_REJECT 16'h0001
`define SWS_EXT_ABORT 16'h0008
`define SWS_EXT_BG_FAIL 16'h0009
`define SWS_EXT_BLK_FAIL 16'h0017
`define SWS_DRV_ACTIVE 8'h00
`define SWS_DRV_BG 8'h05
`endif

// *** inc/sws_pkg.sv ***
// Types shared by the repeated-fill command engine.
// Assumes the constants header is on the include path.
package sws_pkg;
  typedef struct packed {
    logic [15:0] action;
    logic [15:0] func;
    logic [63:0] startLba;
    logic [63:0] count;
    logic [31:0] pattern;
  } sws_key_t;
  typedef struct packed {
    logic [7:0] error;
    logic [7:0] secCnt;
    logic [7:0] secNum;
    logic [7:0] cylLo;
    logic [7:0] cylHi;
    logic [7:0] status;
  } sws_tf_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DATA = 2'b01,
    S_FILL = 2'b11
  } sws_state_t;
endpackage : sws_pkg

// *** rtl/sws_write_same_engine.sv ***
// Repeated-fill command engine: key decode, range check, fill sequencer,
// extended status, whole-drive flag and temperature interval counters.
// Assumes every input comes from logic on sys_clk; no pin is sampled here.
`timescale 1ns/1ns
`include "sws_params.svh"
module sws_write_same_engine (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic keyValid,
  input wire sws_pkg::sws_key_t keyIn,
  input wire logic [63:0] lastUserLba,
  input wire logic sectorDataDone,
  input wire logic hostCmdValid,
  input wire logic hostCmdIsStatus,
  input wire logic mediaAck,
  input wire logic mediaFail,
  input wire logic userSectorWrite,
  input wire logic tempValid,
  input wire logic signed [7:0] tempValue,
  input wire logic signed [7:0] upperOperatingTempLimit,
  input wire logic signed [7:0] lowerOperatingTempLimit,
  output sws_pkg::sws_tf_t taskfileResult,
  output logic taskfileValid,
  output logic cmdComplete,
  output logic mediaWrReq,
  output logic [63:0] mediaLba,
  output logic mediaUseSector,
  output logic [31:0] mediaPattern,
  output logic [15:0] extStatus,
  output logic [7:0] driveStatus,
  output logic wholeDriveInit,
  output logic [31:0] overLimitCount,
  output logic [31:0] underLimitCount
);

  function automatic sws_pkg::sws_tf_t mkTf(input logic ok, input logic [15:0] ext);
    sws_pkg::sws_tf_t t;
    t = '0;
    if (ok)
    begin
      t.error = `SWS_TF_ERR_OK;
      t.cylLo = `SWS_TF_XFER_LO;
      t.cylHi = `SWS_TF_XFER_HI;
      t.status = `SWS_TF_STAT_OK;
    end
    else
    begin
      t.error = `SWS_TF_ERR_ABRT;
      t.secCnt = ext[7:0];
      t.secNum = ext[15:8];
      t.status = `SWS_TF_STAT_ERR;
    end
    return t;
  endfunction : mkTf

  sws_pkg::sws_state_t stateQ, stateD;
  logic blockQ;
  logic wholeQ;
  logic [63:0] endLbaQ;

  // Key decode
  wire isWs = keyIn.action == `SWS_ACT_WRITE_SAME;
  wire fnOk = keyIn.func == `SWS_FN_PAT_BG || keyIn.func == `SWS_FN_SEC_BG ||
              keyIn.func == `SWS_FN_PAT_BLK || keyIn.func == `SWS_FN_SEC_BLK;
  wire keySector = keyIn.func[`SWS_FN_SECTOR_BIT];
  wire keyBlock = keyIn.func[`SWS_FN_BLOCK_BIT];
  wire keyTake = keyValid && isWs && stateQ == sws_pkg::S_IDLE;
  // Sum held at 65 bits so a huge count cannot wrap past the check
  wire [64:0] keySum = {1'b0, keyIn.startLba} + {1'b0, keyIn.count};
  wire zeroCount = keyIn.count == 64'h0;
  wire beyond = keyIn.startLba > lastUserLba ||
                (!zeroCount && keySum > {1'b0, lastUserLba} + 65'h1);
  wire keyReject = keyTake && (beyond || !fnOk);
  wire keyAccept = keyTake && !beyond && fnOk;
  wire [63:0] keyEnd = zeroCount ? lastUserLba : keySum[63:0] - 64'h1;
  wire keyWhole = keyIn.startLba == 64'h0 && keyEnd == lastUserLba;

  // Fill progress
  wire inFill = stateQ == sws_pkg::S_FILL;
  wire sectorOk = inFill && mediaAck && !mediaFail;
  wire lastSector = sectorOk && mediaLba == endLbaQ;
  wire fillFail = inFill && mediaAck && mediaFail;
  wire busyBg = stateQ != sws_pkg::S_IDLE && !blockQ;
  wire hostAbort = busyBg && hostCmdValid && !hostCmdIsStatus;
  wire dataIn = stateQ == sws_pkg::S_DATA && sectorDataDone;

  always_comb
  begin
    stateD = stateQ;
    case (stateQ)
      sws_pkg::S_IDLE:
        if (keyAccept)
          stateD = keySector ? sws_pkg::S_DATA : sws_pkg::S_FILL;
      sws_pkg::S_DATA:
        if (hostAbort)
          stateD = sws_pkg::S_IDLE;
        else if (dataIn)
          stateD = sws_pkg::S_FILL;
      sws_pkg::S_FILL:
        if (hostAbort || lastSector || fillFail)
          stateD = sws_pkg::S_IDLE;
      default:
        stateD = sws_pkg::S_IDLE;
    endcase
  end

  // Completion: background pattern at accept, background sector at end of data, blocking at end of fill
  wire bgDone = (keyAccept && !keySector && !keyBlock) || (dataIn && !blockQ);
  wire blkEnd = blockQ && (lastSector || fillFail);
  wire blkTf = keyAccept || blkEnd || keyReject;

  wire [15:0] extD =
    keyAccept ? `SWS_EXT_BUSY :
    keyReject ? `SWS_EXT_REJECT :
    hostAbort ? `SWS_EXT_ABORT :
    fillFail ? (blockQ ? `SWS_EXT_BLK_FAIL : `SWS_EXT_BG_FAIL) :
    lastSector ? `SWS_EXT_DONE : extStatus;

  wire sws_pkg::sws_tf_t tfD =
    keyReject ? mkTf(1'b0, `SWS_EXT_REJECT) :
    (blkEnd && fillFail) ? mkTf(1'b0, `SWS_EXT_BLK_FAIL) :
    mkTf(1'b1, 16'h0000);

  // Flag: set wins over any clear in the same cycle
  // Abort in the cycle of the last ack reports 0008h, so the flag must stay clear too
  wire initSet = lastSector && wholeQ && !hostAbort;
  wire initClr = userSectorWrite || (sectorOk && !wholeQ) ||
                 (wholeQ && (fillFail || hostAbort));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateQ <= sws_pkg::S_IDLE;
      blockQ <= 1'b0;
      wholeQ <= 1'b0;
      endLbaQ <= 64'h0;
    end
    else
    begin
      stateQ <= stateD;
      if (keyAccept)
      begin
        blockQ <= keyBlock;
        wholeQ <= keyWhole;
        endLbaQ <= keyEnd;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mediaWrReq <= 1'b0;
      mediaLba <= 64'h0;
      mediaUseSector <= 1'b0;
      mediaPattern <= 32'h0;
    end
    else
    begin
      mediaWrReq <= stateD == sws_pkg::S_FILL;
      if (keyAccept)
      begin
        mediaLba <= keyIn.startLba;
        mediaUseSector <= keySector;
        mediaPattern <= keyIn.pattern;
      end
      else if (sectorOk && !lastSector)
        mediaLba <= mediaLba + 64'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      taskfileResult <= '0;
      taskfileValid <= 1'b0;
      cmdComplete <= 1'b0;
      extStatus <= `SWS_EXT_DONE;
      driveStatus <= `SWS_DRV_ACTIVE;
      wholeDriveInit <= 1'b0;
    end
    else
    begin
      taskfileValid <= blkTf;
      if (blkTf)
        taskfileResult <= tfD;
      cmdComplete <= bgDone || blkEnd || keyReject;
      extStatus <= extD;
      driveStatus <= (stateD != sws_pkg::S_IDLE && !(keyAccept ? keyBlock : blockQ)) ?
                     `SWS_DRV_BG : `SWS_DRV_ACTIVE;
      if (initSet)
        wholeDriveInit <= 1'b1;
      else if (initClr)
        wholeDriveInit <= 1'b0;
    end
  end

  // Counters wrap at 2^32; an interval every few seconds never gets there
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overLimitCount <= 32'h0;
      underLimitCount <= 32'h0;
    end
    else if (tempValid)
    begin
      if (tempValue > upperOperatingTempLimit)
        overLimitCount <= overLimitCount + 32'h1;
      if (tempValue < lowerOperatingTempLimit)
        underLimitCount <= underLimitCount + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_ACCEPT_TF: assert property (keyAccept |=> taskfileValid &&
    taskfileResult.status == 8'h50 && taskfileResult.cylLo == 8'h01 &&
    taskfileResult.error == 8'h00 && extStatus == 16'hffff)
    else $error("Accepted key without ready taskfile");
  AST_REJECT: assert property (keyReject |=> taskfileResult.status == 8'h51 &&
    stateQ == sws_pkg::S_IDLE && !mediaWrReq [*2])
    else $error("Out of range key started a fill");
  AST_BUSY_EXT: assert property (stateQ != sws_pkg::S_IDLE |->
    extStatus == 16'hffff)
    else $error("Extended status not busy during fill");
  AST_INCR: assert property (sectorOk && !lastSector |=>
    mediaLba == $past(mediaLba) + 64'h1)
    else $error("Fill address did not increment");
  AST_BOUND: assert property (mediaWrReq |-> mediaLba <= endLbaQ)
    else $error("Fill address past end of range");
  AST_ZERO_COUNT: assert property (keyAccept && zeroCount |=>
    endLbaQ == $past(lastUserLba))
    else $error("Zero count did not run to last user sector");
  AST_ABORT: assert property (hostAbort |=> extStatus == 16'h0008 &&
    stateQ == sws_pkg::S_IDLE)
    else $error("Host command did not end background fill");
  AST_BG_FAIL: assert property (fillFail && !blockQ |=> extStatus == 16'h0009)
    else $error("Background failure code wrong");
  AST_BLK_FAIL: assert property (fillFail && blockQ |=>
    extStatus == 16'h0017 && taskfileResult.secCnt == 8'h17 &&
    taskfileResult.secNum == 8'h00 && taskfileResult.status == 8'h51 && cmdComplete)
    else $error("Blocking failure not reported");
  AST_BLK_HOLD: assert property (stateQ == sws_pkg::S_FILL && blockQ &&
    !lastSector && !fillFail |=> !cmdComplete)
    else $error("Blocking fill completed early");
  AST_DRV_BG: assert property (busyBg |-> driveStatus == 8'h05)
    else $error("Drive status not background");
  AST_INIT_SET: assert property (initSet |=> wholeDriveInit)
    else $error("Whole drive flag not set");
  AST_INIT_CLR: assert property (userSectorWrite && !initSet |=> !wholeDriveInit)
    else $error("Whole drive flag not cleared");
  AST_OVER: assert property (tempValid && tempValue > upperOperatingTempLimit |=>
    overLimitCount == $past(overLimitCount) + 32'h1)
    else $error("Over limit interval not counted");
  AST_UNDER: assert property (tempValid && tempValue < lowerOperatingTempLimit |=>
    underLimitCount == $past(underLimitCount) + 32'h1)
    else $error("Under limit interval not counted");

  // Completion, data wait, abort and counter hold
  AST_REJECT_TF: assert property (keyReject |=> taskfileValid && cmdComplete &&
    taskfileResult.error == 8'h04 && taskfileResult.secCnt == 8'h01 &&
    taskfileResult.secNum == 8'h00 && extStatus == 16'h0001)
    else $error("Rejected key reported wrong codes");
  AST_BG_COMPLETE: assert property (keyAccept && !keySector && !keyBlock |=>
    cmdComplete && driveStatus == 8'h05)
    else $error("Background pattern fill did not complete at once");
  AST_SECTOR_DATA: assert property (dataIn && !blockQ && !hostAbort |=>
    cmdComplete && mediaWrReq && extStatus == 16'hffff)
    else $error("Background sector fill did not complete after data");
  AST_DATA_WAIT: assert property (stateQ == sws_pkg::S_DATA |-> !mediaWrReq)
    else $error("Sector fill wrote before data arrived");
  AST_ABORT_DATA: assert property (stateQ == sws_pkg::S_DATA && hostAbort &&
    !sectorDataDone |=> !mediaWrReq && !cmdComplete)
    else $error("Host command did not end data wait");
  AST_START: assert property (keyAccept |=> mediaLba == $past(keyIn.startLba) &&
    mediaPattern == $past(keyIn.pattern) && mediaUseSector == $past(keySector))
    else $error("Fill did not start from the key fields");
  AST_PATTERN_HOLD: assert property (stateQ != sws_pkg::S_IDLE |=>
    mediaPattern == $past(mediaPattern) && mediaUseSector == $past(mediaUseSector))
    else $error("Fill source changed during fill");
  AST_LAST_DONE: assert property (lastSector && !hostAbort |=>
    extStatus == 16'h0000 && !mediaWrReq)
    else $error("Fill did not stop cleanly after last sector");
  AST_BLK_OK: assert property (blkEnd && !fillFail |=> taskfileValid && cmdComplete &&
    taskfileResult.status == 8'h50 && taskfileResult.error == 8'h00)
    else $error("Blocking fill end not reported");
  AST_FAIL_STOP: assert property (fillFail |=> !mediaWrReq &&
    stateQ == sws_pkg::S_IDLE)
    else $error("Fill went on after unrecoverable error");
  AST_STATUS_KEEP: assert property (inFill && hostCmdValid && hostCmdIsStatus &&
    !mediaAck |=> inFill)
    else $error("Status query ended the fill");
  AST_BLK_NO_ABORT: assert property (inFill && blockQ && hostCmdValid &&
    !mediaAck |=> inFill)
    else $error("Host command cut a blocking fill");
  AST_INIT_PARTIAL: assert property (sectorOk && !wholeQ |=> !wholeDriveInit)
    else $error("Partial fill left whole drive flag set");
  AST_INIT_CUT: assert property (wholeQ && hostAbort |=> !wholeDriveInit)
    else $error("Aborted whole fill set the flag");
  AST_DRV_IDLE: assert property (stateQ == sws_pkg::S_IDLE |->
    driveStatus == 8'h00)
    else $error("Drive status not active while idle");
  AST_OVER_KEEP: assert property (!(tempValid &&
    tempValue > upperOperatingTempLimit) |=> overLimitCount == $past(overLimitCount))
    else $error("Over limit count moved without an interval");
  AST_UNDER_KEEP: assert property (!(tempValid &&
    tempValue < lowerOperatingTempLimit) |=> underLimitCount == $past(underLimitCount))
    else $error("Under limit count moved without an interval");
  AST_NO_WS: assert property (keyValid && !isWs && stateQ == sws_pkg::S_IDLE |=>
    !taskfileValid)
    else $error("Foreign action code answered");

  COV_BG_DONE: cover property (busyBg && lastSector);
  COV_BLK_DONE: cover property (blockQ && lastSector);
  COV_ABORT: cover property (hostAbort);
  COV_WHOLE: cover property (initSet);
  COV_SECTOR_DATA: cover property (dataIn && !blockQ);

endmodule : sws_write_same_engine

// *** bench/sws_host_model.sv ***
// Host and media partner: acknowledges sector writes and supplies sector data.
// Assumes it shares sys_clk and rst_n with the fill engine.
`timescale 1ns/1ns
module sws_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mediaWrReq,
  input wire logic [63:0] mediaLba,
  input wire logic taskfileValid,
  input wire sws_pkg::sws_tf_t taskfileResult,
  input wire logic sectorMode,
  input wire logic [63:0] failLba,
  input wire logic [3:0] delay,
  output logic mediaAck,
  output logic mediaFail,
  output logic sectorDataDone
);
  logic [3:0] waitQ;
  // A gap after each ack keeps a request that is about to drop from a second ack
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitQ <= 4'h0;
      mediaAck <= 1'b0;
      mediaFail <= 1'b0;
      sectorDataDone <= 1'b0;
    end
    else
    begin
      mediaAck <= 1'b0;
      mediaFail <= 1'b0;
      sectorDataDone <= taskfileValid && sectorMode && taskfileResult.status == 8'h50;
      if (mediaWrReq && !mediaAck)
      begin
        if (waitQ >= delay)
        begin
          mediaAck <= 1'b1;
          mediaFail <= (mediaLba == failLba);
          waitQ <= 4'h0;
        end
        else
          waitQ <= waitQ + 4'h1;
      end
    end
  end
endmodule : sws_host_model

// *** bench/sws_write_same_engine_tb.sv ***
// Testbench for the repeated-fill engine: scoreboarded fills, aborts and counters.
// Assumes the package, the engine and the partner model are compiled first.
`timescale 1ns/1ns
module sws_write_same_engine_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic keyValid = 1'b0;
  sws_pkg::sws_key_t keyIn = '0;
  logic [63:0] lastUserLba = 64'h3;
  logic hostCmdValid = 1'b0;
  logic hostCmdIsStatus = 1'b0;
  logic userSectorWrite = 1'b0;
  logic tempValid = 1'b0;
  logic signed [7:0] tempValue = 8'h00;
  logic signed [7:0] upLim = 8'h28;
  logic signed [7:0] loLim = 8'hfb;
  logic sectorMode = 1'b0;
  logic [63:0] failLba = 64'hffff_ffff_ffff_ffff;
  logic [3:0] delay = 4'h0;
  logic sectorDataDone, mediaAck, mediaFail, taskfileValid, cmdComplete;
  logic mediaWrReq, mediaUseSector, wholeDriveInit;
  logic [63:0] mediaLba;
  logic [63:0] expLba = 64'h0;
  logic [31:0] mediaPattern, overLimitCount, underLimitCount;
  logic [31:0] rnd = 32'hf076;
  logic [31:0] expOver = 32'h0;
  logic [31:0] expUnder = 32'h0;
  logic [15:0] extStatus;
  logic [7:0] driveStatus;
  sws_pkg::sws_tf_t taskfileResult;
  logic [47:0] expQ[$];
  logic [47:0] maskQ[$];
  int mismatches = 0;
  int compares = 0;
  int cc = 0;
  int c0 = 0;
  always #25 sys_clk = ~sys_clk;
  sws_write_same_engine sws_write_same_engine_i (
    .sys_clk, .rst_n, .keyValid, .keyIn, .lastUserLba, .sectorDataDone, .hostCmdValid,
    .hostCmdIsStatus, .mediaAck, .mediaFail, .userSectorWrite, .tempValid, .tempValue,
    .upperOperatingTempLimit(upLim), .lowerOperatingTempLimit(loLim), .taskfileResult,
    .taskfileValid, .cmdComplete, .mediaWrReq, .mediaLba, .mediaUseSector, .mediaPattern,
    .extStatus, .driveStatus, .wholeDriveInit, .overLimitCount, .underLimitCount);
  sws_host_model sws_host_model_i (
    .sys_clk, .rst_n, .mediaWrReq, .mediaLba, .taskfileValid, .taskfileResult, .sectorMode,
    .failLba, .delay, .mediaAck, .mediaFail, .sectorDataDone);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // An answer with nothing queued is compared against its own inverse, so it always counts
  task automatic checkTf(input logic [47:0] got);
    logic [47:0] e;
    logic [47:0] m;
    e = ~got;
    m = '1;
    if (expQ.size() > 0)
    begin
      e = expQ.pop_front();
      m = maskQ.pop_front();
    end
    check(got & m, e & m);
  endtask : checkTf
  task automatic pushTf(input logic [47:0] e, input logic [47:0] m);
    expQ.push_back(e);
    maskQ.push_back(m);
  endtask : pushTf
  task automatic sendKey(input logic [15:0] act, input logic [15:0] fn,
                         input logic [63:0] st, input logic [63:0] cnt);
    logic bad;
    bad = st > lastUserLba || (cnt != 64'h0 && st + cnt - 64'h1 > lastUserLba);
    if (act == 16'h0002 && bad)
      pushTf(48'h04_01_00_00_00_51, 48'hff_ff_ff_00_00_ff);
    else if (act == 16'h0002)
      pushTf(48'h00_00_00_01_00_50, 48'hff_00_00_ff_ff_ff);
    expLba = st;
    @(posedge sys_clk);
    keyIn <= '{act, fn, st, cnt, rnd};
    keyValid <= 1'b1;
    @(posedge sys_clk);
    keyValid <= 1'b0;
  endtask : sendKey
  task automatic hostCmd(input logic isStatus);
    hostCmdIsStatus <= isStatus;
    hostCmdValid <= 1'b1;
    @(posedge sys_clk);
    hostCmdValid <= 1'b0;
    @(posedge sys_clk);
  endtask : hostCmd
  task automatic waitDone(input string name);
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (extStatus === 16'hffff && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 400)
    begin
      mismatches++;
      wrap_up;
    end
    // One more edge lets the monitor count the final completion pulse first
    @(posedge sys_clk);
    $display("test %s done", name);
  endtask : waitDone
  always @(posedge sys_clk)
  begin
    if (cmdComplete === 1'b1)
      cc++;
    if (mediaAck === 1'b1)
    begin
      check(mediaLba, expLba);
      expLba++;
    end
    if (taskfileValid === 1'b1)
      checkTf(taskfileResult);
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rnd = lfsr(rnd);
    sendKey(16'h0002, 16'h0001, 64'h0, 64'h2);
    @(posedge sys_clk);
    check(driveStatus, 8'h05);
    check(mediaPattern, rnd);
    check(mediaUseSector, 1'b0);
    waitDone("partial");
    check(extStatus, 16'h0000);
    check(cc, 1);
    check(wholeDriveInit, 1'b0);
    delay <= 4'h3;
    c0 = cc;
    sendKey(16'h0002, 16'h0101, 64'h0, 64'h0);
    pushTf(48'h00_00_00_00_00_50, 48'hff_00_00_00_00_ff);
    repeat (4) @(posedge sys_clk);
    check(cc, c0);
    waitDone("whole");
    check(cc, c0 + 1);
    check(wholeDriveInit, 1'b1);
    userSectorWrite <= 1'b1;
    @(posedge sys_clk);
    userSectorWrite <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(wholeDriveInit, 1'b0);
    sendKey(16'h0002, 16'h0001, 64'h4, 64'h1);
    sendKey(16'h0002, 16'h0001, 64'h2, 64'h3);
    sendKey(16'h0003, 16'h0001, 64'h0, 64'h1);
    repeat (3) @(posedge sys_clk);
    check(mediaWrReq, 1'b0);
    $display("test reject done");
    sectorMode <= 1'b1;
    delay <= 4'hf;
    c0 = cc;
    sendKey(16'h0002, 16'h0002, 64'h0, 64'h3);
    repeat (4) @(posedge sys_clk);
    check(cc, c0 + 1);
    check(mediaUseSector, 1'b1);
    hostCmd(1'b1);
    check(extStatus, 16'hffff);
    hostCmd(1'b0);
    waitDone("abort");
    check(extStatus, 16'h0008);
    check(mediaWrReq, 1'b0);
    sectorMode <= 1'b0;
    delay <= 4'h0;
    failLba <= 64'h1;
    sendKey(16'h0002, 16'h0001, 64'h0, 64'h3);
    waitDone("bgfail");
    check(extStatus, 16'h0009);
    check(driveStatus, 8'h00);
    sectorMode <= 1'b1;
    sendKey(16'h0002, 16'h0102, 64'h1, 64'h2);
    pushTf(48'h04_17_00_00_00_51, 48'hff_ff_ff_00_00_ff);
    waitDone("blkfail");
    check(extStatus, 16'h0017);
    repeat (16)
    begin
      rnd = lfsr(rnd);
      tempValue <= rnd[7:0];
      tempValid <= 1'b1;
      expOver = expOver + 32'($signed(rnd[7:0]) > upLim);
      expUnder = expUnder + 32'($signed(rnd[7:0]) < loLim);
      @(posedge sys_clk);
      tempValid <= 1'b0;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
    check(overLimitCount, expOver);
    check(underLimitCount, expUnder);
    check(expQ.size(), 0);
    $display("test temperature done");
    wrap_up;
  end
endmodule : sws_write_same_engine_tb
